// >>> core/serial_pkg.sv
// Constants shared by the host serial port and its bench.
// Assumes a single system clock; all timing is derived from it.
package serial_pkg;
	// System clock rate and receive oversampling factor.
	localparam int CLK_HZ = 125000000;
	localparam int OVS = 16;
	localparam int DIV_W = 16;
	// Selector position that stops the bit-rate generator.
	localparam logic [3:0] SEL_OFF = 4'h7;
	// Character layout: start, eight data bits, two stop bits.
	localparam int DATA_BITS = 8;
	localparam int STOP_BITS = 2;
	localparam int FRAME_BITS = 11;
	// Sample slots within one bit time.
	localparam logic [3:0] SMP_MID = 4'h7;
	localparam logic [3:0] SMP_LAST = 4'hf;
	// Flow control characters.
	localparam logic [7:0] CHAR_XOFF = 8'h13;
	localparam logic [7:0] CHAR_XON = 8'h11;
	// Buffer sizes and fill thresholds in percent.
	localparam int RX_DEPTH = 128;
	localparam int TX_DEPTH = 8;
	localparam int XOFF_PCT = 50;
	localparam int XON_PCT = 35;
	localparam int PCT_FULL = 100;

	// Bit rate for each selector position; zero means no clock.
	function automatic int baud_of(input logic [3:0] sel);
		case (sel)
			4'h0: baud_of = 300;
			4'h1: baud_of = 600;
			4'h2: baud_of = 1200;
			4'h3: baud_of = 2400;
			4'h4: baud_of = 4800;
			4'h5: baud_of = 9600;
			4'h6: baud_of = 19200;
			4'h8: baud_of = 300;
			4'h9: baud_of = 600;
			default: baud_of = 0;
		endcase
	endfunction
endpackage

// >>> core/host_serial_port.sv
// Host serial port with hardware handshake and XON/XOFF flow control,
// plus the small transmit FIFO that feeds it.
// Assumes all pins are synchronous to clk_sys and rst_n is asynchronous.
//
// Contract
// R1 - Selector positions map to fixed bit rates.
// R2 - Position seven produces no bit clock.
// R3 - Clear-to-send is inverse of holding full.
// R4 - Full buffer holds clear-to-send low.
// R5 - Transmit only while RTS and DTR asserted; code checks both only before the start bit, and a started frame completes.
// R6 - Remote keeps DSR up, waits for permission.
// R7 - Check DTR before load; error if low.
// R8 - Check DSR before receive; error if low.
// R9 - Permission output pulses once per character.
// R10 - Hardware handshake and XON/XOFF run together.
// R11 - Received XOFF suspends transmitter output.
// R12 - Received XON resumes suspended output.
// R13 - Store all received characters in buffer; XON and XOFF are not stored.
// R14 - Send XOFF at half buffer fill.
// R15 - Send XON when drained to 35 percent.
// R16 - Remote stops within 64 bytes after XOFF.
// R17 - Transmitted bit seven always zero.
// R18 - Received bit seven treated as zero.
// R19 - No parity bit either direction.
// R20 - Exactly two stop bits per character.
// R21 - Divisor from selector, 16x receive oversampling.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// Transmit FIFO between the user port and the transmitter.
module tx_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int PW = (D > 1) ? $clog2(D) : 1;
	localparam int CW = $clog2(D + 1);
	localparam logic [CW-1:0] FULL = CW'(D);
	localparam logic [PW-1:0] LAST = PW'(D - 1);

	logic [W-1:0] mem [D];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic push;
	logic pop;

	// Ready and valid follow the fill count, so full and empty are exact.
	assign in_ready = (count != FULL);
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Storage is written only, never reset; the count guards reads.
	always_ff @(posedge clk_sys) begin
		if (clk_en && push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers wrap explicitly so the depth need not be a power of two.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else if (clk_en) begin
			if (push) begin
				wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////
// Serial port top level.
module host_serial_port #(
	parameter int CLK_RATE = serial_pkg::CLK_HZ,
	parameter int RXD = serial_pkg::RX_DEPTH,
	parameter int TXD = serial_pkg::TX_DEPTH
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [3:0] baud_sel,
	input wire logic rxd,
	output logic txd,
	input wire logic rts_in,
	input wire logic dtr_in,
	input wire logic dsr_in,
	output logic cts_out,
	output logic perm_pulse,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic tx_err,
	output logic rx_err,
	output logic tx_suspended
);
	import serial_pkg::*;

	localparam int RPW = $clog2(RXD);
	localparam int RCW = $clog2(RXD + 1);
	localparam logic [RCW-1:0] R_FULL = RCW'(RXD);
	localparam logic [RCW-1:0] XOFF_LVL = RCW'(RXD * XOFF_PCT / PCT_FULL);
	localparam logic [RCW-1:0] XON_LVL = RCW'(RXD * XON_PCT / PCT_FULL);
	localparam logic [3:0] T_LAST = 4'(FRAME_BITS - 1);
	localparam logic [3:0] D_LAST = 4'(DATA_BITS - 1);
	localparam logic [3:0] S_LAST = 4'(STOP_BITS - 1);

	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_WAIT = 3'b010,
		TX_SHIFT = 3'b100
	} tx_state_t;

	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA = 4'b0100,
		RX_STOP = 4'b1000
	} rx_state_t;

	// Divisor for one sample tick; zero stops the generator.
	function automatic logic [DIV_W-1:0] div_of(input logic [3:0] s);
		int b;
		b = baud_of(s);
		if (b == 0 || s == SEL_OFF) begin
			div_of = '0;
		end else begin
			div_of = DIV_W'(CLK_RATE / (OVS * b));
		end
	endfunction

	// Frame built LSB first with bit seven forced low and no parity.
	function automatic logic [FRAME_BITS-1:0] frame_of(input logic [7:0] d);
		frame_of = {{STOP_BITS{1'b1}}, 1'b0, d[6:0], 1'b0};
	endfunction

	////////////////////////////////////////////////////////////////////
	// Bit-rate generator.
	logic [DIV_W-1:0] div;
	logic [DIV_W-1:0] div_cnt;
	logic smp_tick;

	// A changed selector simply restarts the count at the next wrap.
	assign div = div_of(baud_sel); // R1 R21
	assign smp_tick = (div != '0) && (div_cnt == div - 1'b1); // R2

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= '0;
		end else if (clk_en) begin
			if (div == '0 || div_cnt >= div - 1'b1) begin
				div_cnt <= '0; // R2
			end else begin
				div_cnt <= div_cnt + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Receiver.
	rx_state_t rx_state;
	logic [3:0] rx_smp;
	logic [3:0] rx_bits;
	logic [7:0] rx_shift;
	logic rx_bad;
	logic last_stop;
	logic frame_good;
	logic [7:0] rx_char;
	logic got_xoff;
	logic got_xon;

	assign last_stop = (rx_state == RX_STOP) && smp_tick &&
		(rx_smp == SMP_LAST) && (rx_bits == S_LAST); // R20
	assign frame_good = last_stop && !rx_bad && rxd;
	assign rx_char = {1'b0, rx_shift[6:0]}; // R18
	assign got_xoff = frame_good && (rx_char == CHAR_XOFF);
	assign got_xon = frame_good && (rx_char == CHAR_XON);

	// A start bit is confirmed at mid bit; data then sampled at slot 15.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_state <= RX_IDLE;
			rx_smp <= '0;
			rx_bits <= '0;
			rx_shift <= '0;
			rx_bad <= 1'b0;
		end else if (clk_en && smp_tick) begin
			case (rx_state)
				RX_IDLE: begin
					if (!rxd) begin
						rx_state <= RX_START;
						rx_smp <= '0;
						rx_bad <= !dsr_in; // R8
					end
				end
				RX_START: begin
					rx_smp <= rx_smp + 1'b1;
					if (rx_smp == SMP_MID) begin
						rx_smp <= '0;
						rx_bits <= '0;
						rx_state <= rxd ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					rx_smp <= rx_smp + 1'b1;
					if (rx_smp == SMP_LAST) begin
						rx_shift <= {rxd, rx_shift[7:1]};
						rx_bits <= rx_bits + 1'b1;
						if (rx_bits == D_LAST) begin
							// No parity slot follows the data.
							rx_bits <= '0;
							rx_state <= RX_STOP; // R19
						end
					end
				end
				RX_STOP: begin
					rx_smp <= rx_smp + 1'b1;
					if (rx_smp == SMP_LAST) begin
						rx_bits <= rx_bits + 1'b1;
						if (!rxd) begin
							rx_bad <= 1'b1;
						end
						if (rx_bits == S_LAST) begin
							rx_state <= RX_IDLE; // R20
						end
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	// Error pulse for a missing DSR or a broken stop bit.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_err <= 1'b0;
		end else if (clk_en) begin
			rx_err <= last_stop && (rx_bad || !rxd); // R8
		end
	end

	////////////////////////////////////////////////////////////////////
	// Holding register, receive buffer and clear-to-send.
	logic hold_full;
	logic [7:0] hold_data;
	logic [7:0] rx_mem [RXD];
	logic [RPW-1:0] rx_wr;
	logic [RPW-1:0] rx_rd;
	logic [RCW-1:0] rx_count;
	logic rx_push;
	logic rx_pop;
	logic take_char;

	assign take_char = frame_good && !got_xoff && !got_xon;
	assign rx_push = hold_full && (rx_count != R_FULL); // R4
	assign rx_pop = rx_valid && rx_ready;
	assign rx_valid = (rx_count != '0);
	assign rx_data = rx_mem[rx_rd];
	// Low while a byte waits or DSR is absent, so the host must pause.
	assign cts_out = !hold_full && dsr_in; // R3 R4 R10

	// An arrival in the cycle the holding byte moves on wins the flag.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hold_full <= 1'b0;
			hold_data <= '0;
		end else if (clk_en) begin
			if (rx_push) begin
				hold_full <= 1'b0; // R3
			end
			if (take_char) begin
				hold_full <= 1'b1; // R3
				hold_data <= rx_char;
			end
		end
	end

	// One permission pulse each time the holding byte is taken while DSR is high.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			perm_pulse <= 1'b0;
		end else if (clk_en) begin
			perm_pulse <= rx_push && dsr_in; // R9
		end
	end

	// Characters keep being stored after XOFF has gone out.
	always_ff @(posedge clk_sys) begin
		if (clk_en && rx_push) begin
			rx_mem[rx_wr] <= hold_data; // R13
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_wr <= '0;
			rx_rd <= '0;
			rx_count <= '0;
		end else if (clk_en) begin
			if (rx_push) begin
				rx_wr <= rx_wr + 1'b1;
			end
			if (rx_pop) begin
				rx_rd <= rx_rd + 1'b1;
			end
			if (rx_push && !rx_pop) begin
				rx_count <= rx_count + 1'b1;
			end else if (rx_pop && !rx_push) begin
				rx_count <= rx_count - 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Flow control toward the remote party.
	logic xoff_sent;
	logic ctl_pend;
	logic [7:0] ctl_char;
	logic ctl_take;
	tx_state_t tx_state;

	assign ctl_take = (tx_state == TX_IDLE) && ctl_pend;

	// Hysteresis between the two levels avoids XON/XOFF chatter.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			xoff_sent <= 1'b0;
			ctl_pend <= 1'b0;
			ctl_char <= CHAR_XON;
		end else if (clk_en) begin
			if (ctl_take) begin
				ctl_pend <= 1'b0;
			end else if (!xoff_sent && rx_count >= XOFF_LVL) begin
				ctl_pend <= 1'b1;
				ctl_char <= CHAR_XOFF; // R14
				xoff_sent <= 1'b1;
			end else if (xoff_sent && rx_count <= XON_LVL) begin
				ctl_pend <= 1'b1;
				ctl_char <= CHAR_XON; // R15
				xoff_sent <= 1'b0;
			end
		end
	end

	// Output suspension from the remote party's own XOFF and XON.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_suspended <= 1'b0;
		end else if (clk_en) begin
			if (got_xoff) begin
				tx_suspended <= 1'b1; // R11
			end else if (got_xon) begin
				tx_suspended <= 1'b0; // R12
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Transmitter fed by the FIFO.
	logic [7:0] f_data;
	logic f_valid;
	logic f_ready;
	logic [FRAME_BITS-1:0] tx_frame;
	logic [3:0] tx_smp;
	logic [3:0] tx_bits;

	// Control characters bypass suspension; data waits behind them.
	assign f_ready = (tx_state == TX_IDLE) && !ctl_pend && !tx_suspended;

	tx_fifo #(
		.W(8),
		.D(TXD)
	) tx_fifo_inst (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.in_data(tx_data),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(f_ready)
	);

	// A character already started always completes, so a late XOFF
	// lets at most the one in flight go out.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_state <= TX_IDLE;
			tx_frame <= '1;
			tx_smp <= '0;
			tx_bits <= '0;
			txd <= 1'b1;
			tx_err <= 1'b0;
		end else if (clk_en) begin
			tx_err <= 1'b0;
			case (tx_state)
				TX_IDLE: begin
					if (ctl_pend) begin
						tx_frame <= frame_of(ctl_char);
						tx_state <= TX_WAIT;
					end else if (f_valid && f_ready) begin
						if (!dtr_in) begin
							tx_err <= 1'b1; // R7
						end else begin
							tx_frame <= frame_of(f_data); // R17
							tx_state <= TX_WAIT; // R7
						end
					end
				end
				TX_WAIT: begin
					if (rts_in && dtr_in && smp_tick) begin
						txd <= tx_frame[0]; // R5
						tx_frame <= {1'b1, tx_frame[FRAME_BITS-1:1]};
						tx_smp <= '0;
						tx_bits <= '0;
						tx_state <= TX_SHIFT;
					end
				end
				TX_SHIFT: begin
					if (smp_tick) begin
						tx_smp <= tx_smp + 1'b1;
						if (tx_smp == SMP_LAST) begin
							if (tx_bits == T_LAST) begin
								txd <= 1'b1; // R20
								tx_state <= TX_IDLE;
							end else begin
								txd <= tx_frame[0];
								tx_frame <= {1'b1, tx_frame[FRAME_BITS-1:1]};
								tx_bits <= tx_bits + 1'b1;
							end
						end
					end
				end
				default: tx_state <= TX_IDLE;
			endcase
		end
	end
endmodule

// >>> dv/host_serial_port_monitor.sv
// Pin checker for the host serial port, one per port instance.
// Assumes a single clock domain and the ports as the design declares.
`timescale 1ns/1ps
module host_serial_port_monitor (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [3:0] baud_sel,
	input wire logic txd,
	input wire logic rts_in,
	input wire logic dtr_in,
	input wire logic dsr_in,
	input wire logic cts_out,
	input wire logic perm_pulse,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	input wire logic tx_err
);
	import serial_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	// Each property ties an output to its cause at the inputs or to port outputs.
	a_cts_dsr: assert property (!dsr_in |-> !cts_out)
		else $error("cts high while dsr low");
	a_cts_held: assert property (perm_pulse |-> !$past(cts_out))
		else $error("permission without a held byte");
	a_perm_once: assert property (perm_pulse |=> !perm_pulse)
		else $error("permission pulse too long");
	a_perm_store: assert property (perm_pulse |-> rx_valid)
		else $error("permission without stored byte");
	a_rx_msb: assert property (rx_valid |-> !rx_data[7])
		else $error("received top bit not zero");
	a_err_dtr: assert property (tx_err |-> !$past(dtr_in))
		else $error("transmit error with dtr high");
	// A falling edge only starts a frame when the stimulus holds rts.
	a_start_rts: assert property ($fell(txd) |-> $past(rts_in && dtr_in))
		else $error("line active without rts and dtr");
	a_off_still: assert property ((baud_sel == SEL_OFF &&
		$past(baud_sel) == SEL_OFF && $past(txd)) |-> txd)
		else $error("line moved with bit clock off");
endmodule
bind host_serial_port host_serial_port_monitor host_serial_port_monitor_inst (
	.clk_sys(clk_sys), .rst_n(rst_n), .baud_sel(baud_sel), .txd(txd),
	.rts_in(rts_in), .dtr_in(dtr_in), .dsr_in(dsr_in), .cts_out(cts_out),
	.perm_pulse(perm_pulse), .rx_data(rx_data), .rx_valid(rx_valid),
	.tx_err(tx_err));

// >>> dv/host_term.sv
// Behavioural host terminal on the far side of the serial lines.
// Assumes a fixed bit time in system clocks given by BIT.
`timescale 1ns/1ps
module host_term #(
	parameter int BIT = 96
) (
	input wire logic clk_sys,
	input wire logic txd,
	input wire logic cts_out,
	output logic rxd
);
	logic [7:0] got[$];
	logic [7:0] bad = 8'h00;
	initial rxd = 1'b1;
	////////////////////////////////////////
	// Sends one character; w low skips the wait so faults can be made.
	task automatic send(input logic [7:0] d, input logic w);
		logic [10:0] f;
		f = {2'b11, d, 1'b0};
		// With w high the model never sends past a refusal, so it stops well inside
		// the margin after an XOFF.
		while (w && cts_out !== 1'b1) @(negedge clk_sys);
		for (int i = 0; i < 11; i++) begin
			rxd = f[i];
			repeat (BIT) @(negedge clk_sys);
		end
	endtask
	// Decodes device frames at mid-bit; a low stop bit is counted.
	always begin : rx_frame
		logic [7:0] d;
		@(negedge txd);
		repeat (BIT / 2) @(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk_sys);
			d[i] = txd;
		end
		repeat (2) begin
			repeat (BIT) @(posedge clk_sys);
			if (txd !== 1'b1) bad++;
		end
		got.push_back(d);
	end
endmodule

// >>> dv/host_serial_port_tb.sv
// Self-checking bench for the host serial port with a host model.
// Assumes the package and design compile first; one clock domain.
`timescale 1ns/1ps
module host_serial_port_tb;
	import serial_pkg::*;
	// A slow clock rate keeps frames short: 19200 gives 96 clocks a bit.
	localparam int RATE = 1920000;
	localparam int BIT = RATE / (OVS * 19200) * OVS;
	logic clk_sys, rst_n, clk_en, rxd, txd, rts_in, dtr_in, dsr_in;
	logic cts_out, perm_pulse, tx_valid, tx_ready, rx_valid, rx_ready;
	logic tx_err, rx_err, tx_suspended, cts_lo;
	logic [3:0] baud_sel;
	logic [7:0] tx_data, rx_data;
	int num_errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	assign cts_lo = !cts_out;
	// A shallow receive buffer brings both flow levels within reach.
	host_serial_port #(.CLK_RATE(RATE), .RXD(8)) host_serial_port_inst (
		.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
		.baud_sel(baud_sel), .rxd(rxd), .txd(txd), .rts_in(rts_in),
		.dtr_in(dtr_in), .dsr_in(dsr_in), .cts_out(cts_out),
		.perm_pulse(perm_pulse), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .tx_err(tx_err), .rx_err(rx_err),
		.tx_suspended(tx_suspended));
	host_term #(.BIT(BIT)) host_term_inst (.clk_sys(clk_sys), .txd(txd),
		.cts_out(cts_out), .rxd(rxd));
	////////////////////////////////////////
	// Free-running 125 MHz clock.
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// Cuts a hang short; the tests need about 20000 cycles.
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checked %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, s);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	function automatic logic [7:0] cnt();
		return 8'(host_term_inst.got.size());
	endfunction
	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// Polls at falling edges so a one-cycle pulse is never missed.
	task automatic seen(input string n, ref logic s, input int lim);
		int k;
		k = 0;
		while (s !== 1'b1 && k < lim) begin
			idle(1);
			k++;
		end
		chk(n, 8'h01, {7'h00, s});
	endtask
	task automatic got_wait(input logic [7:0] n);
		int k;
		k = 0;
		while (cnt() <= n && k < 3000) begin
			idle(1);
			k++;
		end
	endtask
	// Holds valid until an edge where ready is high.
	task automatic push(input logic [7:0] d);
		tx_data = d;
		tx_valid = 1'b1;
		while (tx_ready !== 1'b1) idle(1);
		idle(1);
		tx_valid = 1'b0;
	endtask
	////////////////////////////////////////
	task automatic t_tx();
		logic [7:0] n;
		n = cnt();
		rts_in = 1'b0;
		push(8'hc5);
		idle(BIT * 4);
		chk("held", n, cnt());
		rts_in = 1'b1;
		got_wait(n);
		chk("txbyte", 8'h45, host_term_inst.got[n]);
		chk("stops", 0, host_term_inst.bad);
	endtask
	task automatic t_dtr();
		logic [7:0] n;
		n = cnt();
		dtr_in = 1'b0;
		push(8'h5a);
		seen("txerr", tx_err, 50);
		idle(BIT * 12);
		chk("dropped", n, cnt());
		dtr_in = 1'b1;
	endtask
	task automatic t_rx();
		fork
			host_term_inst.send(8'ha3, 1'b1);
			begin
				seen("ctslow", cts_lo, 1500);
				seen("perm", perm_pulse, 4);
			end
		join
		chk("rxvalid", 1, rx_valid);
		chk("rxbyte", 8'h23, rx_data);
		rx_ready = 1'b1;
		idle(1);
		rx_ready = 1'b0;
		chk("popped", 0, rx_valid);
	endtask
	task automatic t_flow();
		logic [7:0] n;
		host_term_inst.send(CHAR_XOFF, 1'b1);
		idle(BIT * 2);
		chk("susp", 1, tx_suspended);
		chk("unstored", 0, rx_valid);
		n = cnt();
		push(8'h31);
		idle(BIT * 14);
		chk("paused", n, cnt());
		host_term_inst.send(CHAR_XON, 1'b1);
		got_wait(n);
		chk("resumed", 8'h31, host_term_inst.got[n]);
		chk("unsusp", 0, tx_suspended);
	endtask
	task automatic t_dsr();
		dsr_in = 1'b0;
		idle(2);
		chk("ctsoff", 0, cts_out);
		fork
			host_term_inst.send(8'h44, 1'b0);
			seen("rxerr", rx_err, 1500);
		join
		chk("nostore", 0, rx_valid);
		dsr_in = 1'b1;
	endtask
	task automatic t_off();
		logic [7:0] n;
		n = cnt();
		baud_sel = SEL_OFF;
		push(8'h12);
		idle(BIT * 14);
		chk("nobits", n, cnt());
		chk("idle", 1, txd);
		baud_sel = 4'h6;
		got_wait(n);
		chk("late", 8'h12, host_term_inst.got[n]);
	endtask
	// Four stored bytes reach half of eight; draining two reaches XON.
	task automatic t_lvl();
		logic [7:0] n;
		n = cnt();
		repeat (4) host_term_inst.send(8'h41, 1'b1);
		got_wait(n);
		chk("xoff", CHAR_XOFF, host_term_inst.got[n]);
		chk("stored", 8'h41, rx_data);
		n = cnt();
		rx_ready = 1'b1;
		idle(2);
		rx_ready = 1'b0;
		got_wait(n);
		chk("xon", CHAR_XON, host_term_inst.got[n]);
		rx_ready = 1'b1;
		idle(2);
		rx_ready = 1'b0;
		chk("drained", 0, rx_valid);
	endtask
	// Main sequence; inputs change only at falling edges.
	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		baud_sel = 4'h6;
		{rts_in, dtr_in, dsr_in} = 3'b111;
		tx_data = 8'h00;
		tx_valid = 1'b0;
		rx_ready = 1'b0;
		idle(6);
		rst_n = 1'b1;
		idle(1);
		chk("rstidle", 1, txd);
		chk("rstcts", 1, cts_out);
		t_tx();
		t_dtr();
		t_rx();
		t_flow();
		t_dsr();
		t_off();
		t_lvl();
		conclude();
	end
endmodule
